/* core/sep_defines.svh */
// constants for the serial memory command port: frame lengths, opcodes, timing
// assumes a 200 MHz core clock; included by bare name
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH

`define SEP_CLK_PERIOD_PS     5000
`define SEP_CYCLE_TIME_MS     5
`define SEP_CYCLE_CLKS        ((`SEP_CYCLE_TIME_MS * 1000000) / (`SEP_CLK_PERIOD_PS / 1000))
`define SEP_CLEAR_FRAC        2
`define SEP_OP_READ           2'h2
`define SEP_OP_CLEAR          2'h3
`define SEP_OP_WRITE          2'h1
`define SEP_OP_SPECIAL        2'h0
`define SEP_FN_UNLOCK         2'h3
`define SEP_FN_LOCK           2'h0
`define SEP_FN_CLEAR_ALL      2'h2
`define SEP_FN_FILL_ALL       2'h1
`define SEP_ERASED_BYTE       8'hff
`define SEP_WORDS_X8          512
`define SEP_ADDR_BITS_X8      9
`define SEP_ADDR_BITS_X16     8
`define SEP_DATA_BITS_X8      5'h08
`define SEP_DATA_BITS_X16     5'h10

`endif

/* core/sep_pkg.sv */
// types shared by the serial memory command port
// assumes sep_defines.svh constants for widths
package sep_pkg;

  typedef enum logic [2:0] {
    SEP_JOB_NONE,
    SEP_JOB_WRITE,
    SEP_JOB_CLEAR,
    SEP_JOB_CLEAR_ALL,
    SEP_JOB_FILL_ALL
  } sep_job_t;

  // request from the frame decoder to the program engine
  typedef struct packed {
    sep_job_t    job;
    logic [8:0]  byte_addr;
    logic [15:0] data;
    logic        wide;
  } sep_prog_req_t;

endpackage

/* core/sep_pin_sync.sv */
// two-flop synchroniser for a bundle of pin levels
// assumes inputs are asynchronous levels from the pins
`timescale 1ns/1ps
`default_nettype none
module sep_pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // pin levels in, synchronised out
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] pins_sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= pins;
      stage2_reg <= stage1_reg;
    end
  end

  assign pins_sync = stage2_reg;

endmodule
`default_nettype wire

/* core/sep_cycle_timer.sv */
// self-timed program cycle timer: clear phase then program phase
// assumes start is a one-cycle pulse from the same clock
`timescale 1ns/1ps
`include "sep_defines.svh"
`default_nettype none
module sep_cycle_timer #(
  parameter int CYCLE_CLKS = `SEP_CYCLE_CLKS
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      clear_phase,
  output logic      done
);

  localparam int CLEAR_CLKS = CYCLE_CLKS / `SEP_CLEAR_FRAC;

  logic [31:0] count_reg;
  logic        busy_reg;
  logic        done_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_reg <= 32'h0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg  <= 1'b1;
        count_reg <= 32'h0;
      end else if (busy_reg) begin
        if (count_reg == 32'(CYCLE_CLKS - 1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        count_reg <= count_reg + 32'h1;
      end
    end
  end

  assign busy        = busy_reg;
  assign done        = done_reg;
  assign clear_phase = busy_reg && (count_reg < 32'(CLEAR_CLKS));

endmodule
`default_nettype wire

/* core/sep_eeprom_port.sv */
// serial memory command port: frame decoder, read streamer, write lock, program engine
// assumes pins arrive asynchronous; serial clock far slower than the core clock
`timescale 1ns/1ps
`include "sep_defines.svh"
`default_nettype none
module sep_eeprom_port #(
  parameter int CYCLE_CLKS = `SEP_CYCLE_CLKS,
  parameter int WORDS_X8   = `SEP_WORDS_X8
) (
  // clock and power-on reset
  input  wire logic clock,
  input  wire logic reset_n,
  // serial pins
  input  wire logic chip_select,
  input  wire logic serial_clock_in,
  input  wire logic serial_input,
  input  wire logic word_width_select,
  output logic      serial_out,
  output logic      serial_out_oe_n,
  // status
  output logic      write_unlocked,
  output logic      cycle_busy
);

  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_READ, ST_DONE} sep_state_t;

  // ------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------
  logic [3:0] pins_sync;
  sep_pin_sync #(.WIDTH(4)) u_sync (
    .clock     (clock),
    .reset_n   (reset_n),
    .pins      ({word_width_select, serial_input, serial_clock_in, chip_select}),
    .pins_sync (pins_sync)
  );

  wire cs_s   = pins_sync[0];
  wire sk_s   = pins_sync[1];
  wire di_s   = pins_sync[2];
  wire wide_s = pins_sync[3];

  logic sk_prev_reg;
  logic cs_prev_reg;
  wire  sk_rise = sk_s && !sk_prev_reg && cs_s;
  wire  cs_fall = cs_prev_reg && !cs_s;
  wire  cs_rise = cs_s && !cs_prev_reg;

  // ------------------------------------------------------------
  // storage: byte array, a 16-bit word is two bytes, high first
  // ------------------------------------------------------------
  logic [7:0] mem_reg [WORDS_X8];

  sep_state_t    state_reg;
  logic [1:0]    op_reg;
  logic [8:0]    addr_reg;
  logic [15:0]   data_reg;
  logic [4:0]    cnt_reg;
  logic          wide_reg;
  logic          latch_reg;
  logic          out_reg;
  logic          oe_n_reg;
  logic          status_reg;
  logic          first_bit_reg;
  logic [15:0]   shift_reg;
  sep_pkg::sep_prog_req_t req_reg;

  // width pin picks address and data length
  wire [4:0] addr_len = wide_reg ? 5'(`SEP_ADDR_BITS_X16) : 5'(`SEP_ADDR_BITS_X8);
  wire [4:0] data_len = wide_reg ? `SEP_DATA_BITS_X16 : `SEP_DATA_BITS_X8;
  wire [8:0] addr_top = wide_reg ? {addr_reg[7:0], 1'b0} : addr_reg;
  wire [8:0] addr_in  = {addr_reg[7:0], di_s};
  wire [1:0] fn_in    = wide_reg ? addr_in[7:6] : addr_in[8:7];
  wire [8:0] addr_last = wide_reg ? 9'h0ff : 9'h1ff;
  wire [8:0] addr_inc  = (addr_reg == addr_last) ? 9'h000 : addr_reg + 9'h001;
  wire [8:0] rd_byte   = wide_reg ? {addr_reg[7:0], 1'b0} : addr_reg;
  wire [15:0] rd_word  = wide_reg ? {mem_reg[rd_byte], mem_reg[rd_byte | 9'h001]}
                                  : {mem_reg[rd_byte], 8'h00};
  wire [8:0] nx_byte   = wide_reg ? {addr_inc[7:0], 1'b0} : addr_inc;
  wire [15:0] nx_word  = wide_reg ? {mem_reg[nx_byte], mem_reg[nx_byte | 9'h001]}
                                  : {mem_reg[nx_byte], 8'h00};
  wire       addr_done = (cnt_reg == addr_len - 5'h01);
  wire       data_done = (cnt_reg == data_len - 5'h01);

  // ------------------------------------------------------------
  // program engine
  // ------------------------------------------------------------
  logic timer_busy;
  logic timer_clear;
  logic timer_done;
  logic prog_start_reg;

  sep_cycle_timer #(.CYCLE_CLKS(CYCLE_CLKS)) u_timer (
    .clock       (clock),
    .reset_n     (reset_n),
    .start       (prog_start_reg),
    .busy        (timer_busy),
    .clear_phase (timer_clear),
    .done        (timer_done)
  );

  wire timer_phase_end = timer_busy && !timer_clear;
  logic prog_phase_reg;
  logic [31:0] busy_len_reg;

  // ------------------------------------------------------------
  // frame decoder and serial output
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sk_prev_reg    <= 1'b0;
      cs_prev_reg    <= 1'b0;
      state_reg      <= ST_IDLE;
      op_reg         <= 2'h0;
      addr_reg       <= 9'h000;
      data_reg       <= 16'h0000;
      cnt_reg        <= 5'h00;
      wide_reg       <= 1'b1;
      latch_reg      <= 1'b0;
      out_reg        <= 1'b0;
      oe_n_reg       <= 1'b1;
      status_reg     <= 1'b0;
      first_bit_reg  <= 1'b0;
      shift_reg      <= 16'h0000;
      prog_start_reg <= 1'b0;
      req_reg        <= '0;
    end else begin
      sk_prev_reg    <= sk_s;
      cs_prev_reg    <= cs_s;
      prog_start_reg <= 1'b0;
      // cleared first so a job set in the same cycle wins
      if (timer_done) begin
        req_reg.job <= sep_pkg::SEP_JOB_NONE;
      end
      if (cs_rise) begin
        wide_reg <= wide_s;
        state_reg <= ST_IDLE;
        // status shown on select during a cycle
        if (req_reg.job != sep_pkg::SEP_JOB_NONE || timer_busy) begin
          status_reg <= 1'b1;
          oe_n_reg   <= 1'b0;
          out_reg    <= 1'b0;
        end
      end else if (cs_fall) begin
        oe_n_reg   <= 1'b1;
        status_reg <= 1'b0;
        if (state_reg == ST_DONE && req_reg.job != sep_pkg::SEP_JOB_NONE && !timer_busy) begin
          prog_start_reg <= 1'b1;
        end
        state_reg <= ST_IDLE;
      end else if (status_reg) begin
        // low while busy, high when ready
        out_reg <= !(timer_busy || prog_start_reg);
        // a one on input floats status
        if (sk_rise && di_s) begin
          oe_n_reg   <= 1'b1;
          status_reg <= 1'b0;
        end
      end else if (sk_rise && !timer_busy) begin
        unique case (state_reg)
          ST_IDLE: begin
            if (di_s) begin
              state_reg <= ST_OPCODE;
              cnt_reg   <= 5'h00;
            end
          end
          ST_OPCODE: begin
            op_reg  <= {op_reg[0], di_s};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == 5'h01) begin
              state_reg <= ST_ADDR;
              cnt_reg   <= 5'h00;
            end
          end
          ST_ADDR: begin
            addr_reg <= addr_in;
            cnt_reg  <= cnt_reg + 5'h01;
            if (addr_done) begin
              cnt_reg   <= 5'h00;
              state_reg <= ST_DONE;
              unique case (op_reg)
                `SEP_OP_READ: begin
                  state_reg     <= ST_READ;
                  oe_n_reg      <= 1'b0;
                  out_reg       <= 1'b0;
                  first_bit_reg <= 1'b1;
                end
                `SEP_OP_CLEAR: begin
                  req_reg <= '{job: latch_reg ? sep_pkg::SEP_JOB_CLEAR : sep_pkg::SEP_JOB_NONE,
                               byte_addr: wide_reg ? {addr_in[7:0], 1'b0} : addr_in,
                               data: 16'hffff, wide: wide_reg};
                end
                `SEP_OP_WRITE: state_reg <= ST_DATA;
                default: begin
                  unique case (fn_in)
                    `SEP_FN_UNLOCK: latch_reg <= 1'b1;
                    `SEP_FN_LOCK: latch_reg <= 1'b0;
                    `SEP_FN_CLEAR_ALL: begin
                      req_reg <= '{job: latch_reg ? sep_pkg::SEP_JOB_CLEAR_ALL
                                                  : sep_pkg::SEP_JOB_NONE,
                                   byte_addr: 9'h000, data: 16'hffff, wide: wide_reg};
                    end
                    default: state_reg <= ST_DATA;
                  endcase
                end
              endcase
            end
          end
          ST_DATA: begin
            data_reg <= {data_reg[14:0], di_s};
            cnt_reg  <= cnt_reg + 5'h01;
            if (data_done) begin
              state_reg <= ST_DONE;
              // writes only take effect when unlocked
              if (latch_reg) begin
                req_reg.job <= (op_reg == `SEP_OP_WRITE) ? sep_pkg::SEP_JOB_WRITE
                                                         : sep_pkg::SEP_JOB_FILL_ALL;
              end
              req_reg.byte_addr <= addr_top;
              req_reg.data      <= wide_reg ? {data_reg[14:0], di_s}
                                            : {data_reg[6:0], di_s, 8'h00};
              req_reg.wide      <= wide_reg;
            end
          end
          ST_READ: begin
            if (first_bit_reg) begin
              first_bit_reg <= 1'b0;
              out_reg       <= rd_word[15];
              shift_reg     <= {rd_word[14:0], 1'b0};
              cnt_reg       <= 5'h01;
            end else if (cnt_reg == data_len) begin
              addr_reg  <= addr_inc;
              out_reg   <= nx_word[15];
              shift_reg <= {nx_word[14:0], 1'b0};
              cnt_reg   <= 5'h01;
            end else begin
              out_reg   <= shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'b0};
              cnt_reg   <= cnt_reg + 5'h01;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // memory update: clear phase then program phase
  // ------------------------------------------------------------
  wire job_all = req_reg.job == sep_pkg::SEP_JOB_CLEAR_ALL ||
                 req_reg.job == sep_pkg::SEP_JOB_FILL_ALL;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prog_phase_reg <= 1'b0;
      busy_len_reg   <= 32'h0;
    end else begin
      prog_phase_reg <= timer_phase_end;
      busy_len_reg   <= timer_busy ? busy_len_reg + 32'h1 : 32'h0;
    end
  end

  // one generate loop over bytes; storage has no reset, as a real array
  for (genvar i = 0; i < WORDS_X8; i++) begin : g_byte
    wire [8:0] idx    = 9'(i);
    wire       hit    = job_all || (idx == req_reg.byte_addr) ||
                        (req_reg.wide && idx == (req_reg.byte_addr | 9'h001));
    wire [7:0] prog_b = (req_reg.wide && idx[0]) ? req_reg.data[7:0] : req_reg.data[15:8];
    always_ff @(posedge clock) begin
      if (timer_busy && timer_clear && hit) begin
        mem_reg[i] <= `SEP_ERASED_BYTE;
      end else if (timer_phase_end && !prog_phase_reg && hit &&
                   (req_reg.job == sep_pkg::SEP_JOB_WRITE ||
                    req_reg.job == sep_pkg::SEP_JOB_FILL_ALL)) begin
        mem_reg[i] <= prog_b;
      end
    end
  end

  assign serial_out      = out_reg;
  assign serial_out_oe_n = oe_n_reg;
  assign write_unlocked  = latch_reg;
  assign cycle_busy      = timer_busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_busy_select;
    cs_rise && timer_busy;
  endsequence

  chk_locked_reset: assert property (@(posedge clock)
    $rose(reset_n) |-> !latch_reg)
    else $error("write latch set after reset");
  chk_idle_float: assert property (@(posedge clock) disable iff (!reset_n)
    !cs_s && !cs_fall |=> serial_out_oe_n)
    else $error("output driven while deselected");
  chk_busy_low: assert property (@(posedge clock) disable iff (!reset_n)
    s_busy_select ##2 (status_reg && timer_busy) |-> !serial_out && !serial_out_oe_n)
    else $error("status not low while busy");
  chk_status_float: assert property (@(posedge clock) disable iff (!reset_n)
    status_reg && sk_rise && di_s && !cs_fall |=> serial_out_oe_n)
    else $error("status not floated by dummy one");
  chk_read_zero: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(first_bit_reg) |-> !serial_out && !serial_out_oe_n)
    else $error("read dummy bit not zero");
  chk_lock_blocks: assert property (@(posedge clock) disable iff (!reset_n)
    !latch_reg && req_reg.job == sep_pkg::SEP_JOB_NONE |=> 
      req_reg.job == sep_pkg::SEP_JOB_NONE)
    else $error("write accepted while locked");
  chk_start_fall: assert property (@(posedge clock) disable iff (!reset_n)
    prog_start_reg |-> $past(cs_fall) ##1 timer_busy)
    else $error("cycle start not tied to select fall");
  chk_cycle_len: assert property (@(posedge clock) disable iff (!reset_n)
    timer_busy |-> busy_len_reg < 32'(CYCLE_CLKS))
    else $error("program cycle overruns");

endmodule
`default_nettype wire

/* test/sep_host_model.sv */
// host side of the serial memory port: select, serial clock, serial data in
// assumes the core clock drives all pin changes; serial clock idles low
`timescale 1ns/1ps
`default_nettype none
module sep_host_model (
  // core clock
  input  wire logic clock,
  // pins toward the device
  output var logic  chip_select,
  output var logic  serial_clock_in,
  output var logic  serial_input,
  // pin from the device
  input  wire logic serial_out
);
  // half period of the serial clock, well above the device's 4-cycle minimum
  localparam int HALF = 8;

  initial begin
    chip_select     = 1'b0;
    serial_clock_in = 1'b0;
    serial_input    = 1'b0;
  end

  // ------------------------------------------------
  // pin tasks
  // ------------------------------------------------
  // deselect held long enough
  task automatic select(input logic level);
    @(posedge clock);
    chip_select     <= level;
    serial_clock_in <= 1'b0;
    repeat (HALF) @(posedge clock);
  endtask

  // bit set up before the rise
  // a dummy one is just a bit of 1
  task automatic clock_bit(input logic b, output logic seen);
    @(posedge clock);
    serial_clock_in <= 1'b0;
    serial_input    <= b;
    repeat (HALF) @(posedge clock);
    serial_clock_in <= 1'b1;
    repeat (HALF) @(posedge clock);
    seen = serial_out;
  endtask

  task automatic send(input logic [31:0] v, input int n);
    logic s;
    for (int i = n - 1; i >= 0; i--) begin
      clock_bit(v[i], s);
    end
  endtask

  task automatic shift_in(input int n, output logic [31:0] got);
    logic s;
    got = 32'h0;
    for (int i = 0; i < n; i++) begin
      clock_bit(1'b0, s);
      got = {got[30:0], s};
    end
  endtask
endmodule
`default_nettype wire

/* test/sep_eeprom_port_bench.sv */
// self-checking bench for the serial memory command port
// assumes a short program cycle through CYCLE_CLKS; host model drives the pins
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_port_bench;
  localparam int CYCLE = 40;
  logic      clock;
  logic      reset_n;
  logic      wide;
  wire logic cs;
  wire logic sk;
  wire logic di;
  wire logic dout;
  wire logic oe_n;
  wire logic dline;
  wire logic unlocked;
  wire logic busy;
  int        fail_count;
  int        checked;

  sep_eeprom_port #(.CYCLE_CLKS(CYCLE)) i_sep_eeprom_port (
    .clock(clock), .reset_n(reset_n), .chip_select(cs), .serial_clock_in(sk),
    .serial_input(di), .word_width_select(wide), .serial_out(dout),
    .serial_out_oe_n(oe_n), .write_unlocked(unlocked), .cycle_busy(busy));

  // a floated output shows the inverse so late or missing drive is caught
  assign dline = oe_n ? ~dout : dout;

  sep_host_model i_sep_host_model (
    .clock(clock), .chip_select(cs), .serial_clock_in(sk), .serial_input(di),
    .serial_out(dline));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ------------------------------------------------
  // checking and closing
  // ------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // frame helpers
  // ------------------------------------------------
  // select stays high afterwards so reads can stream on
  task automatic frame(input logic [1:0] op, input logic [8:0] addr,
                       input logic [15:0] data, input int dbits);
    i_sep_host_model.select(1'b1);
    i_sep_host_model.send({29'h0, 1'b1, op}, 3);
    i_sep_host_model.send({23'h0, addr}, wide ? 8 : 9);
    if (dbits > 0) begin
      i_sep_host_model.send({16'h0, data}, dbits);
    end
  endtask

  task automatic job(input logic [1:0] op, input logic [8:0] addr, input logic [15:0] data,
                     input int dbits);
    frame(op, addr, data, dbits);
    i_sep_host_model.select(1'b0);
  endtask

  task automatic read_check(input logic [8:0] addr, input int n, input logic [31:0] exp);
    logic [31:0] got;
    frame(2'h2, addr, 16'h0, 0);
    check({oe_n, dout}, 2'b00);
    i_sep_host_model.shift_in(n, got);
    check(got, exp);
    i_sep_host_model.select(1'b0);
  endtask

  // status poll after a program cycle, bounded
  task automatic wait_ready();
    int   n;
    logic s;
    i_sep_host_model.select(1'b1);
    check({busy, oe_n, dout}, 3'b100);
    n = 0;
    while (dline !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) begin
      fail_count++;
      print_verdict();
    end
    repeat (2) @(posedge clock);
    check({busy, oe_n, n <= CYCLE}, 3'b001);
    i_sep_host_model.clock_bit(1'b1, s);
    check(oe_n, 1'b1);
    i_sep_host_model.select(1'b0);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_locked_write();
    job(2'h1, 9'h005, 16'hdead, 16);
    repeat (20) @(posedge clock);
    check({unlocked, busy}, 2'b00);
    job(2'h0, 9'h0c0, 16'h0, 0);
    check(unlocked, 1'b1);
  endtask

  task automatic t_write_read();
    job(2'h1, 9'h005, 16'ha5c3, 16);
    wait_ready();
    job(2'h1, 9'h0ff, 16'h1234, 16);
    wait_ready();
    job(2'h3, 9'h000, 16'h0, 0);
    wait_ready();
    read_check(9'h005, 16, 32'ha5c3);
    read_check(9'h0ff, 32, 32'h1234ffff);
  endtask

  // byte pair of word 5 read as two bytes with the width pin low
  task automatic t_narrow();
    @(posedge clock);
    wide <= 1'b0;
    read_check(9'h00a, 16, 32'ha5c3);
    @(posedge clock);
    wide <= 1'b1;
  endtask

  task automatic t_lock();
    job(2'h0, 9'h000, 16'h0, 0);
    check(unlocked, 1'b0);
    job(2'h3, 9'h005, 16'h0, 0);
    repeat (20) @(posedge clock);
    check(busy, 1'b0);
    read_check(9'h005, 16, 32'ha5c3);
    job(2'h0, 9'h0c0, 16'h0, 0);
  endtask

  task automatic t_all();
    job(2'h0, 9'h040, 16'h0f0f, 16);
    wait_ready();
    read_check(9'h080, 16, 32'h0f0f);
    job(2'h0, 9'h080, 16'h0, 0);
    wait_ready();
    read_check(9'h033, 16, 32'hffff);
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    fail_count = 0;
    checked    = 0;
    reset_n    = 1'b0;
    wide       = 1'b1;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
    check({oe_n, unlocked, busy}, 3'b100);
    t_locked_write();
    t_write_read();
    t_narrow();
    t_lock();
    t_all();
    check(oe_n, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
